/* rtl/pws_core.v */
// Watchdogs, reset cause, link errors and status byte of a peripheral card
`include "pws_defs.vh"
`default_nettype none

// Functional notes
// [R1] Enable select 0 turns on both watchdogs, 1 hardware only, 2 software only.
// [R2] Hardware watchdog is kicked internally; on timeout the card is hard reset.
// [R3] Hardware watchdog, once on, stays on until a hard reset.
// [R4] Software watchdog expiring without refresh causes a soft reset.
// [R5] Master must refresh the software watchdog before it expires.
// [R6] Master sets timeout, then enables, before refreshing.
// [R7] Refresh answers with the current count, 25 ms per unit.
// [R8] Reset cause: bit7 hard, bit6 soft, bit5 hw on, bit4 sw on.
// [R9] Reading reset cause or link errors clears the bits reported.
// [R10] Link errors: 7 waiting, 6 collision, 5 overrun, 4 mode, 3 compare.
// [R11] Status bits 7:6: 01 ready, 10 busy, 11 not connected.
// [R12] Status bit 5: 0 end device, 1 router.
// [R13] Status bit 4 set while any link error is flagged.
// [R14] Status bits 3:2 are card specific.
// [R15] Status bit 1: previous command accepted 0, not executed 1.
// [R16] Status bit 0 set when either watchdog has expired.
// [R17] Status sent in a frame describes the preceding command.
// [R18] Timeout 0.025 to 6.375 s in 25 ms steps; zero disables.
// [R19] Hard reset clears everything; soft reset only the processor.
// [R20] Count reloads on refresh and decrements every 25 ms.
module pws_core #(
  parameter [19:0] SW_TICK_CYC = `PWS_SW_TICK_CYC, // Cycles per 25 ms
  parameter [24:0] HW_WDT_CYC = `PWS_HW_WDT_CYC, // Hardware watchdog period
  parameter IS_ROUTER = 0 // Responder type
) (
  input wire clk, // Card clock, 25 MHz
  input wire rst, // Hard reset, synchronous, active high
  input wire ss_n, // Link select pin, active low
  input wire sclk, // Link clock pin
  input wire mosi, // Link data in pin
  output wire miso_o, // Link data out value
  output wire miso_oe, // Link data out enable
  input wire hw_wdt_kick, // Internal hardware watchdog kick pulse
  input wire card_busy, // Card busy level
  input wire [1:0] card_bits, // Card-specific status bits
  output reg hard_reset_req, // Hard reset request, held until reset
  output reg soft_reset_req, // Soft reset pulse
  output reg hw_wdt_on, // Hardware watchdog enabled
  output reg sw_wdt_on // Software watchdog running
);

  // ****************************************
  // Command decoding
  // ****************************************
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_CMD = 3'h1;
  localparam [2:0] ST_ARG = 3'h2;
  localparam [2:0] ST_RPL = 3'h3;
  localparam [2:0] ST_DONE = 3'h4;

  function needs_arg;
    input [7:0] c;
    begin
      needs_arg = (c == `PWS_CMD_WDT_EN) || (c == `PWS_CMD_SW_TMO);
    end
  endfunction

  function has_reply;
    input [7:0] c;
    begin
      has_reply = (c == `PWS_CMD_SW_HIT) || (c == `PWS_CMD_RC_RD) ||
        (c == `PWS_CMD_ERR_RD);
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  reg [2:0] state_q;
  reg [7:0] cmd_q;
  reg [7:0] rpl_q;
  reg hw_en_q;
  reg sw_en_q;
  reg [7:0] sw_tmo_q;
  reg [7:0] sw_cnt_q;
  reg [19:0] tick_q;
  reg [24:0] hw_cnt_q;
  reg [1:0] rc_q;
  reg [4:0] err_q;
  reg expired_q;
  reg last_bad_q;

  wire sel;
  wire frame_start;
  wire frame_end;
  wire partial;
  wire mode_err;
  wire rx_valid;
  wire [7:0] rx_byte;
  wire tx_load;
  wire [7:0] tx_byte;

  // ****************************************
  // Link
  // ****************************************
  pws_link u_link (
    .clk(clk),
    .rst(rst),
    .ss_n_pin(ss_n),
    .sclk_pin(sclk),
    .mosi_pin(mosi),
    .tx_byte(tx_byte),
    .tx_load(tx_load),
    .miso_o(miso_o),
    .miso_oe(miso_oe),
    .sel(sel),
    .frame_start(frame_start),
    .frame_end(frame_end),
    .partial(partial),
    .mode_err(mode_err),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte)
  );

  // ****************************************
  // Status and reply bytes
  // ****************************************
  wire sw_run = sw_en_q && (sw_tmo_q != 8'h00); // R18
  wire [1:0] sb_state = card_busy ? `PWS_SB_BUSY : `PWS_SB_READY; // R11
  wire sb_router = (IS_ROUTER != 0); // R12
  wire [7:0] status_byte = {sb_state, sb_router, (err_q != 5'h00), // R13
    card_bits, last_bad_q, expired_q}; // R14 R15 R16
  wire [7:0] rc_byte = {rc_q, hw_en_q, sw_en_q, 4'h0}; // R8
  wire [7:0] err_byte = {err_q, 3'h0}; // R10

  reg [7:0] reply_val;
  always @* begin
    case (rx_byte)
      `PWS_CMD_SW_HIT: reply_val = sw_cnt_q; // R7
      `PWS_CMD_RC_RD: reply_val = rc_byte;
      `PWS_CMD_ERR_RD: reply_val = err_byte;
      default: reply_val = 8'h00;
    endcase
  end

  wire cmd_byte = rx_valid && (state_q == ST_CMD);
  wire arg_byte = rx_valid && (state_q == ST_ARG);
  wire rpl_done = rx_valid && (state_q == ST_RPL);
  // Status is latched at select, before this frame's command exists
  assign tx_load = frame_start | (cmd_byte && has_reply(rx_byte)); // R17
  assign tx_byte = frame_start ? status_byte : reply_val;

  // ****************************************
  // Command effects
  // ****************************************
  wire hit_cmd = cmd_byte && (rx_byte == `PWS_CMD_SW_HIT);
  wire hit_ok = hit_cmd && sw_run;
  wire en_cmd = arg_byte && (cmd_q == `PWS_CMD_WDT_EN);
  wire tmo_cmd = arg_byte && (cmd_q == `PWS_CMD_SW_TMO);
  wire en_bad = en_cmd && (rx_byte > `PWS_WSEL_SW);
  wire en_hw = en_cmd && ((rx_byte == `PWS_WSEL_BOTH) || (rx_byte == `PWS_WSEL_HW)); // R1
  wire en_sw = en_cmd && ((rx_byte == `PWS_WSEL_BOTH) || (rx_byte == `PWS_WSEL_SW)); // R1
  wire rc_read = rpl_done && (cmd_q == `PWS_CMD_RC_RD);
  wire err_read = rpl_done && (cmd_q == `PWS_CMD_ERR_RD);

  // ****************************************
  // Software watchdog
  // ****************************************
  wire tick = sw_run && (tick_q == SW_TICK_CYC - 20'h00001);
  wire sw_expire = tick && (sw_cnt_q <= 8'h01) && !hit_ok; // R4

  always @(posedge clk) begin
    if (rst) begin
      sw_en_q <= 1'b0;
      sw_tmo_q <= 8'h00;
      sw_cnt_q <= 8'h00;
      tick_q <= 20'h00000;
      soft_reset_req <= 1'b0;
      sw_wdt_on <= 1'b0;
    end else begin
      soft_reset_req <= sw_expire; // R4
      sw_wdt_on <= sw_run;
      if (en_sw) begin
        sw_en_q <= 1'b1;
      end
      if (tmo_cmd) begin
        sw_tmo_q <= rx_byte; // R18
      end
      if (hit_ok || en_sw || tmo_cmd) begin
        sw_cnt_q <= tmo_cmd ? rx_byte : sw_tmo_q; // R20
        tick_q <= 20'h00000;
      end else if (!sw_run) begin
        tick_q <= 20'h00000;
      end else if (tick) begin
        tick_q <= 20'h00000;
        // Reload after expiry so the card keeps being watched
        sw_cnt_q <= sw_expire ? sw_tmo_q : sw_cnt_q - 8'h01; // R20
      end else begin
        tick_q <= tick_q + 20'h00001;
      end
    end
  end

  // ****************************************
  // Hardware watchdog
  // ****************************************
  wire hw_expire = hw_en_q && !hard_reset_req &&
    (hw_cnt_q == HW_WDT_CYC - 25'h0000001); // R2

  always @(posedge clk) begin
    if (rst) begin
      hw_en_q <= 1'b0; // R3
      hw_cnt_q <= 25'h0000000;
      hard_reset_req <= 1'b0;
      hw_wdt_on <= 1'b0;
    end else begin
      hw_wdt_on <= hw_en_q;
      if (en_hw) begin
        hw_en_q <= 1'b1; // R3
      end
      if (!hw_en_q || hw_wdt_kick || en_hw) begin
        hw_cnt_q <= 25'h0000000; // R2
      end else if (!hard_reset_req) begin
        hw_cnt_q <= hw_cnt_q + 25'h0000001;
      end
      // Held until the reset generator answers with rst
      if (hw_expire) begin
        hard_reset_req <= 1'b1; // R2 R19
      end
    end
  end

  // ****************************************
  // Frame sequencing
  // ****************************************
  always @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cmd_q <= 8'h00;
      rpl_q <= 8'h00;
      last_bad_q <= 1'b0;
    end else begin
      if (frame_start) begin
        state_q <= ST_CMD;
      end else if (frame_end || !sel) begin
        state_q <= ST_IDLE;
      end else if (rx_valid) begin
        case (state_q)
          ST_CMD: begin
            cmd_q <= rx_byte;
            rpl_q <= reply_val;
            if (needs_arg(rx_byte)) begin
              state_q <= ST_ARG;
            end else if (has_reply(rx_byte)) begin
              state_q <= ST_RPL;
            end else begin
              state_q <= ST_DONE;
            end
          end
          ST_ARG: state_q <= ST_DONE;
          ST_RPL: state_q <= ST_DONE;
          default: state_q <= state_q;
        endcase
      end
      // Outcome of the command, reported in the next frame
      // Verdict taken at the command byte, or at the argument byte if there is one; a frame ending before its argument or reply byte sets it
      if (cmd_byte) begin
        last_bad_q <= (!needs_arg(rx_byte) && !has_reply(rx_byte)) || (hit_cmd && !sw_run); // R15
      end else if (arg_byte) begin
        last_bad_q <= en_bad; // R15
      end else if (frame_end && (state_q == ST_ARG || state_q == ST_RPL)) begin
        last_bad_q <= 1'b1; // R15
      end
    end
  end

  // ****************************************
  // Reset cause, link errors, expiry flag
  // ****************************************
  wire [1:0] rc_set = {1'b0, sw_expire};
  // Only the bits the master actually saw are cleared; new events win
  wire [1:0] rc_clr = rc_read ? rpl_q[7:6] : 2'h0; // R9
  wire [4:0] err_clr = err_read ? rpl_q[7:3] : 5'h00; // R9
  reg [4:0] err_set;

  always @* begin
    err_set = 5'h00;
    err_set[`PWS_ER_RX_WAIT - 3] = frame_end && partial;
    err_set[`PWS_ER_COLL - 3] = frame_end && (state_q == ST_RPL);
    err_set[`PWS_ER_OVR - 3] = rx_valid && (state_q == ST_DONE);
    err_set[`PWS_ER_MODE - 3] = mode_err;
    err_set[`PWS_ER_CMP - 3] = en_bad;
  end

  always @(posedge clk) begin
    if (rst) begin
      rc_q <= `PWS_RC_RESET; // R19
      err_q <= `PWS_ER_RESET;
      expired_q <= 1'b0;
    end else begin
      rc_q <= (rc_q & ~rc_clr) | rc_set; // R8 R9
      err_q <= (err_q & ~err_clr) | err_set; // R10 R9
      if (sw_expire || hw_expire) begin
        expired_q <= 1'b1; // R16
      end else if (rc_read) begin
        expired_q <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

/* rtl/pws_defs.vh */
// Constants for the peripheral watchdog and status block
`ifndef PWS_DEFS_VH
`define PWS_DEFS_VH

// ****************************************
// Timing
// ****************************************
`define PWS_CLK_KHZ 25000
`define PWS_SW_TICK_MS 25
// Sized to their counters: 25 ms and 1000 ms at 25 MHz
`define PWS_SW_TICK_CYC 20'h98968
`define PWS_HW_WDT_MS 1000
`define PWS_HW_WDT_CYC 25'h17D7840

// ****************************************
// Command codes (first byte of a frame)
// ****************************************
`define PWS_CMD_WDT_EN 8'h20
`define PWS_CMD_SW_HIT 8'h21
`define PWS_CMD_SW_TMO 8'h22
`define PWS_CMD_RC_RD 8'h23
`define PWS_CMD_ERR_RD 8'h24

// ****************************************
// Watchdog select codes
// ****************************************
`define PWS_WSEL_BOTH 8'h00
`define PWS_WSEL_HW 8'h01
`define PWS_WSEL_SW 8'h02

// ****************************************
// Reset-cause byte
// ****************************************
`define PWS_RC_HW_RST 7
`define PWS_RC_SW_RST 6
`define PWS_RC_HW_EN 5
`define PWS_RC_SW_EN 4
`define PWS_RC_RESET 2'h2

// ****************************************
// Link-error byte
// ****************************************
`define PWS_ER_RX_WAIT 7
`define PWS_ER_COLL 6
`define PWS_ER_OVR 5
`define PWS_ER_MODE 4
`define PWS_ER_CMP 3
`define PWS_ER_RESET 5'h00

// ****************************************
// Status byte
// ****************************************
`define PWS_SB_READY 2'h1
`define PWS_SB_BUSY 2'h2
`define PWS_SB_NOCONN 2'h3

`endif

/* rtl/pws_link.v */
// Serial link slave: pin synchronisers, byte shifter, frame events
`default_nettype none

module pws_link (
  input wire clk, // Card clock
  input wire rst, // Synchronous reset, active high
  input wire ss_n_pin, // Select pin, active low
  input wire sclk_pin, // Link clock pin
  input wire mosi_pin, // Data in pin
  input wire [7:0] tx_byte, // Byte to send next
  input wire tx_load, // Load tx_byte into the shifter
  output wire miso_o, // Data out pin value
  output reg miso_oe, // Data out pin enable
  output reg sel, // Filtered select level
  output reg frame_start, // Pulse at select assertion
  output reg frame_end, // Pulse at select release
  output reg partial, // Frame ended inside a byte
  output reg mode_err, // Pulse: link clock high at select
  output reg rx_valid, // Pulse: byte received
  output reg [7:0] rx_byte // Received byte
);

  reg [2:0] ss_s;
  reg [2:0] ck_s;
  reg [2:0] mo_s;
  reg ck_f;
  reg mo_f;
  reg [2:0] bit_q;
  reg [7:0] rx_sh;
  reg [7:0] tx_sh;

  // A change counts once the second and third stages agree
  wire ss_fall = ~ss_s[1] & ~ss_s[2] & ~sel;
  wire ss_rise = ss_s[1] & ss_s[2] & sel;
  wire ck_rise = ck_s[1] & ck_s[2] & ~ck_f;
  wire ck_fall = ~ck_s[1] & ~ck_s[2] & ck_f;
  wire mo_cur = (mo_s[1] == mo_s[2]) ? mo_s[1] : mo_f;

  assign miso_o = tx_sh[7];

  always @(posedge clk) begin
    if (rst) begin
      ss_s <= 3'h7;
      ck_s <= 3'h0;
      mo_s <= 3'h0;
      ck_f <= 1'b0;
      mo_f <= 1'b0;
      sel <= 1'b0;
      miso_oe <= 1'b0;
      frame_start <= 1'b0;
      frame_end <= 1'b0;
      partial <= 1'b0;
      mode_err <= 1'b0;
      rx_valid <= 1'b0;
      rx_byte <= 8'h00;
      bit_q <= 3'h0;
      rx_sh <= 8'h00;
      tx_sh <= 8'h00;
    end else begin
      ss_s <= {ss_s[1:0], ss_n_pin};
      ck_s <= {ck_s[1:0], sclk_pin};
      mo_s <= {mo_s[1:0], mosi_pin};
      mo_f <= mo_cur;
      frame_start <= ss_fall;
      frame_end <= ss_rise;
      mode_err <= ss_fall & ck_f;
      rx_valid <= 1'b0;
      if (ss_rise) begin
        partial <= (bit_q != 3'h0);
      end
      if (ss_fall) begin
        sel <= 1'b1;
        miso_oe <= 1'b1;
        bit_q <= 3'h0;
      end else if (ss_rise) begin
        sel <= 1'b0;
        miso_oe <= 1'b0;
      end
      if (ck_rise) begin
        ck_f <= 1'b1;
      end else if (ck_fall) begin
        ck_f <= 1'b0;
      end
      // Mode 0: sample on rising edge, shift out on falling edge
      if (sel && ck_rise) begin
        rx_sh <= {rx_sh[6:0], mo_cur};
        bit_q <= bit_q + 3'h1;
        if (bit_q == 3'h7) begin
          rx_valid <= 1'b1;
          rx_byte <= {rx_sh[6:0], mo_cur};
        end
      end
      if (tx_load) begin
        tx_sh <= tx_byte;
      end else if (sel && ck_fall && bit_q != 3'h0) begin
        tx_sh <= {tx_sh[6:0], 1'b0};
      end
    end
  end

endmodule

`default_nettype wire

/* testbench/pws_core_props.sv */
// Port checker for the watchdog and status block
`default_nettype none
module pws_core_props #(
  parameter [19:0] SW_TICK_CYC = 20'd20, // Cycles per unit
  parameter [24:0] HW_WDT_CYC = 25'd200, // Hardware period
  parameter IS_ROUTER = 0 // Responder type
) (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic ss_n, // Select
  input wire logic sclk, // Link clock
  input wire logic mosi, // Data in
  input wire logic miso_o, // Data out
  input wire logic miso_oe, // Data enable
  input wire logic hw_wdt_kick, // Kick
  input wire logic card_busy, // Busy
  input wire logic [1:0] card_bits, // Card bits
  input wire logic hard_reset_req, // Hard request
  input wire logic soft_reset_req, // Soft request
  input wire logic hw_wdt_on, // Hw on
  input wire logic sw_wdt_on // Sw on
);
  // ******
  // Properties
  // ******
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_reset_clear: assert property (disable iff (1'b0) rst |=>
    !hw_wdt_on && !sw_wdt_on && !hard_reset_req && !miso_oe)
    else $error("outputs not cleared by reset");
  a_hw_sticky: assert property (hw_wdt_on |=> hw_wdt_on)
    else $error("hardware watchdog turned off");
  a_hard_cause: assert property ($rose(hard_reset_req) |-> $past(hw_wdt_on))
    else $error("hard request without hardware watchdog");
  a_hard_hold: assert property (hard_reset_req |=> hard_reset_req)
    else $error("hard request dropped before reset");
  a_soft_pulse: assert property (soft_reset_req |=> !soft_reset_req)
    else $error("soft request longer than one cycle");
  a_soft_cause: assert property (soft_reset_req |-> $past(sw_wdt_on))
    else $error("soft request without software watchdog");
  a_oe_rise: assert property ($fell(ss_n) |-> ##[2:8] miso_oe)
    else $error("data enable late after select");
  a_oe_fall: assert property ($rose(ss_n) |-> ##[1:8] !miso_oe)
    else $error("data enable held after release");
  a_oe_idle: assert property (ss_n [*8] |-> !miso_oe)
    else $error("data driven while not selected");
  cover property (soft_reset_req);
  cover property ($rose(hard_reset_req));
  cover property ($rose(hw_wdt_on));
endmodule
bind pws_core pws_core_props #(
  .SW_TICK_CYC(SW_TICK_CYC), .HW_WDT_CYC(HW_WDT_CYC), .IS_ROUTER(IS_ROUTER)
) u_props (
  .clk(clk), .rst(rst), .ss_n(ss_n), .sclk(sclk), .mosi(mosi),
  .miso_o(miso_o), .miso_oe(miso_oe), .hw_wdt_kick(hw_wdt_kick),
  .card_busy(card_busy), .card_bits(card_bits), .hard_reset_req(hard_reset_req),
  .soft_reset_req(soft_reset_req), .hw_wdt_on(hw_wdt_on), .sw_wdt_on(sw_wdt_on)
);
`default_nettype wire

/* testbench/pws_master.sv */
// Master model driving select-framed serial frames
`default_nettype none
module pws_master (
  input wire logic clk, // Card clock
  output logic ss_n, // Select, active low
  output logic sclk, // Link clock
  output logic mosi, // Data to card
  input wire logic miso_o, // Card data
  input wire logic miso_oe // Card data enable
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_q = 1'b0;
  // Released line shows a flipped level so a stale bit cannot pass
  wire logic miso_w = miso_oe ? miso_o : ~last_q;
  initial begin
    ss_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Four card clocks per half period gives 320 ns
  task automatic shift_byte(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      mosi = d[i];
      wait_clk(4);
      sclk = 1'b1;
      q[i] = miso_w;
      last_q = miso_w;
      wait_clk(4);
      sclk = 1'b0;
    end
  endtask
  // Link clock stands still low between frames
  task automatic frame(input logic [7:0] c, input logic [7:0] a,
    output logic [7:0] st, output logic [7:0] rp);
    ss_n = 1'b0;
    wait_clk(16);
    shift_byte(c, st);
    wait_clk(16);
    shift_byte(a, rp);
    wait_clk(4);
    ss_n = 1'b1;
    mosi = ~mosi;
    wait_clk(8);
  endtask
endmodule
`default_nettype wire

/* testbench/tb_pws_core.sv */
// Bench for the watchdog and status block
`include "pws_defs.vh"
`default_nettype none
module tb_pws_core;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic rst;
  logic hw_wdt_kick;
  logic card_busy;
  logic [1:0] card_bits;
  wire logic ss_n, sclk, mosi, miso_o, miso_oe;
  wire logic hard_reset_req, soft_reset_req, hw_wdt_on, sw_wdt_on;
  logic [7:0] st, rp;
  int n, n_mismatch = 0, total_checks = 0;
  always #20 clk = ~clk;
  // Short unit and period keep the run brief
  pws_core #(.SW_TICK_CYC(20'h000C8), .HW_WDT_CYC(25'h0000190)) uut (
    .clk(clk), .rst(rst), .ss_n(ss_n), .sclk(sclk), .mosi(mosi),
    .miso_o(miso_o), .miso_oe(miso_oe), .hw_wdt_kick(hw_wdt_kick),
    .card_busy(card_busy), .card_bits(card_bits), .hard_reset_req(hard_reset_req),
    .soft_reset_req(soft_reset_req), .hw_wdt_on(hw_wdt_on), .sw_wdt_on(sw_wdt_on));
  pws_master m (.clk(clk), .ss_n(ss_n), .sclk(sclk), .mosi(mosi),
    .miso_o(miso_o), .miso_oe(miso_oe));
  // ******
  // Helpers
  // ******
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic fr(input logic [7:0] c, input logic [7:0] a, input logic [7:0] es);
    m.frame(c, a, st, rp);
    chk(st, es);
  endtask
  task automatic wait_req(input bit hard, input int lim);
    for (n = 0; n < lim; n++) begin
      m.wait_clk(1);
      if ((hard ? hard_reset_req : soft_reset_req) === 1'b1) break;
    end
    if (n == lim) begin
      chk(8'h00, 8'h01);
      give_verdict;
    end
  endtask
  // ******
  // Sequence
  // ******
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    hw_wdt_kick = 1'b0;
    card_busy = 1'b0;
    card_bits = 2'b01;
    m.wait_clk(8);
    rst = 1'b0;
    m.wait_clk(4);
    fr(`PWS_CMD_RC_RD, 8'h00, 8'h44);
    chk(rp, 8'h80);
    fr(`PWS_CMD_RC_RD, 8'h00, 8'h44);
    chk(rp, 8'h00);
    // Dummy byte after an unknown command lands as an overrun
    fr(8'h55, 8'h00, 8'h44);
    fr(`PWS_CMD_SW_HIT, 8'h00, 8'h56);
    fr(`PWS_CMD_WDT_EN, 8'h03, 8'h56);
    fr(`PWS_CMD_ERR_RD, 8'h00, 8'h56);
    chk(rp, 8'h28);
    fr(`PWS_CMD_ERR_RD, 8'h00, 8'h44);
    chk(rp, 8'h00);
    card_bits = 2'b10;
    fr(`PWS_CMD_SW_TMO, 8'h0A, 8'h48);
    fr(`PWS_CMD_WDT_EN, `PWS_WSEL_SW, 8'h48);
    chk({6'h00, sw_wdt_on, hw_wdt_on}, 8'h02);
    fr(`PWS_CMD_SW_HIT, 8'h00, 8'h48);
    chk(rp, 8'h0A);
    wait_req(1'b0, 2400);
    chk({7'h00, n > 1600}, 8'h01);
    fr(`PWS_CMD_RC_RD, 8'h00, 8'h49);
    chk(rp, 8'h50);
    fr(`PWS_CMD_SW_TMO, 8'h00, 8'h48);
    chk({7'h00, sw_wdt_on}, 8'h00);
    card_busy = 1'b1;
    fr(`PWS_CMD_WDT_EN, `PWS_WSEL_BOTH, 8'h88);
    chk({7'h00, hw_wdt_on}, 8'h01);
    repeat (6) begin
      hw_wdt_kick = 1'b1;
      m.wait_clk(1);
      hw_wdt_kick = 1'b0;
      m.wait_clk(99);
    end
    chk({7'h00, hard_reset_req}, 8'h00);
    fr(`PWS_CMD_WDT_EN, `PWS_WSEL_SW, 8'h88);
    chk({7'h00, hw_wdt_on}, 8'h01);
    wait_req(1'b1, 600);
    rst = 1'b1;
    m.wait_clk(2);
    rst = 1'b0;
    m.wait_clk(4);
    chk({6'h00, hard_reset_req, hw_wdt_on}, 8'h00);
    fr(`PWS_CMD_RC_RD, 8'h00, 8'h88);
    chk(rp, 8'h80);
    fr(`PWS_CMD_WDT_EN, `PWS_WSEL_HW, 8'h88);
    chk({6'h00, sw_wdt_on, hw_wdt_on}, 8'h01);
    give_verdict;
  end
endmodule
`default_nettype wire
